// ===== inc/pst_pkg.sv
package pst_pkg;
    // ==========================================
    // Timing
    localparam longint CLK_HZ = 125_000_000;
    localparam longint DELAY_WAIT_S = 14;
    localparam longint DELAY_WAIT_CYC = DELAY_WAIT_S * CLK_HZ;
    localparam longint KEY_TIMEOUT_S = 20;
    localparam longint KEY_TIMEOUT_CYC = KEY_TIMEOUT_S * CLK_HZ;
    localparam longint BLINK_MS = 250;
    localparam longint BLINK_CYC = BLINK_MS * (CLK_HZ / 1000);
    localparam logic [1:0] BELL_RINGS = 2'h3;
    localparam logic [1:0] BELL_ONCE = 2'h1;

    // ==========================================
    // Step table: bit 8 marks a full-test-only step
    localparam int FULL_BIT = 8;
    localparam int NUM_STEPS = 30;
    localparam logic [4:0] LAST_STEP = 5'h1D;
    localparam logic [7:0] CODE_ALL_ON = 8'hFF;
    localparam logic [7:0] CODE_KEYS = 8'hFC;
    localparam logic [7:0] CODE_DISPLAY_DONE = 8'h8C;
    localparam logic [8:0] STEP_TAB [0:NUM_STEPS-1] = '{
        9'h1FE, 9'h1FC, 9'h0EF, 9'h0EE, 9'h0EC, 9'h0DF, 9'h1BF, 9'h1BE,
        9'h0BD, 9'h0BC, 9'h0B5, 9'h0BA, 9'h0DE, 9'h1B9, 9'h1B8, 9'h0B7,
        9'h0B6, 9'h0B4, 9'h0FA, 9'h0CE, 9'h08F, 9'h18E, 9'h08D, 9'h08C,
        9'h0AF, 9'h0EB, 9'h0DD, 9'h1DC, 9'h0CD, 9'h0CC
    };

    // ==========================================
    // Sequencer states
    typedef enum logic [3:0] {
        PST_START, PST_LAMPS, PST_SELECT, PST_KEYS, PST_RUN,
        PST_REP_NAME, PST_REP_PART, PST_FATAL, PST_SUB, PST_DONE
    } pst_state_e;
endpackage

// ===== core/pst_sequencer.sv
`timescale 1ns/10ps
module pst_sequencer #(
    parameter logic [31:0] DELAY_CYC = 32'(pst_pkg::DELAY_WAIT_CYC),
    parameter logic [31:0] KEY_CYC = 32'(pst_pkg::KEY_TIMEOUT_CYC),
    parameter logic [31:0] BLINK_CYC = 32'(pst_pkg::BLINK_CYC)
) (
    input wire logic clk, // System clock
    input wire logic rst_n, // Master reset, low active
    input wire logic self_test_btn, // Self-test button held
    input wire logic key_press, // Any key struck
    input wire logic return_press, // Return key struck
    input wire logic ctrl_d, // Control-D entered
    input wire logic chk_pass, // Check passed
    input wire logic chk_fail, // Check failed, non-fatal
    input wire logic chk_fatal, // Check failed, fatal
    input wire logic [1:0] sub_count, // Submessage levels of failure
    input wire logic [7:0] sub_code, // Code for selected level
    input wire logic delay_req, // Start one 32K delay wait
    output logic [7:0] indicator_leds, // Eight indicator lights
    output logic shift_lock_lamp, // Shift lock lamp
    output logic [3:0] keyboard_lamps, // Other keyboard lamps
    output logic bell, // Bell strike pulse
    output logic check_start, // Start check pulse
    output logic [7:0] check_code, // Code of current check
    output logic [1:0] sub_sel, // Submessage level shown
    output logic report_valid, // Screen report line pulse
    output logic report_line, // 0 name, 1 failing part
    output logic [7:0] report_code, // Code for screen line
    output logic delay_done, // Delay wait finished pulse
    output logic delay_skip, // Delay memory check skipped
    output logic full_test, // Full self-test pass
    output logic seq_done // Sequence complete
);
    // ==========================================
    // State
    pst_pkg::pst_state_e state_r;
    logic [4:0] idx_r;
    logic [7:0] leds_r;
    logic shift_r;
    logic [3:0] lamps_r;
    logic bell_r;
    logic start_r;
    logic [7:0] code_r;
    logic [1:0] sub_idx_r;
    logic [1:0] sub_max_r;
    logic fatal_r;
    logic rep_r;
    logic rep_line_r;
    logic [7:0] rep_code_r;
    logic disp_ok_r;
    logic skip_r;
    logic full_r;
    logic done_r;
    logic [1:0] rings_r;
    logic [31:0] blink_cnt_r;
    logic tick_r;
    logic [31:0] key_cnt_r;
    logic [31:0] dly_cnt_r;
    logic dly_busy_r;
    logic dly_done_r;
    logic [8:0] entry;
    logic last_step;
    logic key_timeout;

    assign entry = pst_pkg::STEP_TAB[idx_r];
    assign last_step = (idx_r == pst_pkg::LAST_STEP);
    assign key_timeout = (key_cnt_r >= KEY_CYC - 32'h1);

    // ==========================================
    // Blink divider
    always_ff @(posedge clk) begin
        if (!rst_n || blink_cnt_r >= BLINK_CYC - 32'h1) begin
            blink_cnt_r <= 32'h0;
            tick_r <= rst_n;
        end else begin
            blink_cnt_r <= blink_cnt_r + 32'h1;
            tick_r <= 1'b0;
        end
    end

    // ==========================================
    // Key wait timer
    always_ff @(posedge clk) begin
        if (!rst_n || state_r != pst_pkg::PST_KEYS) begin
            key_cnt_r <= 32'h0;
        end else begin
            key_cnt_r <= key_cnt_r + 32'h1;
        end
    end

    // ==========================================
    // Delay memory wait
    // per block wait
    always_ff @(posedge clk) begin
        dly_done_r <= 1'b0;
        if (!rst_n) begin
            dly_busy_r <= 1'b0;
            dly_cnt_r <= 32'h0;
        end else if (delay_req && skip_r) begin
            dly_done_r <= 1'b1;
        end else if (delay_req) begin
            dly_busy_r <= 1'b1;
            dly_cnt_r <= 32'h0;
        end else if (dly_busy_r) begin
            dly_cnt_r <= dly_cnt_r + 32'h1;
            if (dly_cnt_r >= DELAY_CYC - 32'h1) begin
                dly_busy_r <= 1'b0;
                dly_done_r <= 1'b1;
            end
        end
    end

    // ==========================================
    // Control-D capture
    // skip flag set
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            skip_r <= 1'b0;
        end else if (state_r == pst_pkg::PST_KEYS && ctrl_d) begin
            skip_r <= 1'b1;
        end
    end

    // ==========================================
    // Main sequencer
    always_ff @(posedge clk) begin
        start_r <= 1'b0;
        rep_r <= 1'b0;
        bell_r <= 1'b0;
        if (!rst_n) begin
            state_r <= pst_pkg::PST_START;
            idx_r <= 5'h0;
            leds_r <= 8'h00;
            shift_r <= 1'b0;
            lamps_r <= 4'h0;
            code_r <= 8'h00;
            sub_idx_r <= 2'h0;
            sub_max_r <= 2'h0;
            fatal_r <= 1'b0;
            rep_line_r <= 1'b0;
            rep_code_r <= 8'h00;
            disp_ok_r <= 1'b0;
            full_r <= 1'b0;
            done_r <= 1'b0;
            rings_r <= 2'h0;
        end else begin
            case (state_r)
                pst_pkg::PST_START: begin
                    full_r <= self_test_btn;
                    leds_r <= pst_pkg::CODE_ALL_ON;
                    shift_r <= 1'b1;
                    lamps_r <= 4'hF;
                    state_r <= pst_pkg::PST_LAMPS;
                end
                pst_pkg::PST_LAMPS: begin
                    shift_r <= 1'b0;
                    idx_r <= 5'h0;
                    state_r <= pst_pkg::PST_SELECT;
                end
                pst_pkg::PST_SELECT: begin
                    sub_idx_r <= 2'h0;
                    if (entry[pst_pkg::FULL_BIT] && !full_r) begin
                        if (last_step) begin
                            state_r <= pst_pkg::PST_DONE;
                        end else begin
                            idx_r <= idx_r + 5'h1;
                        end
                    end else begin
                        leds_r <= entry[7:0];
                        code_r <= entry[7:0];
                        if (entry[7:0] == pst_pkg::CODE_KEYS) begin
                            bell_r <= 1'b1;
                            state_r <= pst_pkg::PST_KEYS;
                        end else begin
                            start_r <= 1'b1;
                            state_r <= pst_pkg::PST_RUN;
                        end
                    end
                end
                pst_pkg::PST_KEYS: begin
                    shift_r <= tick_r ? ~shift_r : shift_r;
                    if (key_press || key_timeout) begin
                        shift_r <= 1'b0;
                        state_r <= last_step ? pst_pkg::PST_DONE : pst_pkg::PST_SELECT;
                        idx_r <= idx_r + 5'h1;
                    end
                end
                pst_pkg::PST_RUN: begin
                    if (chk_fatal || chk_fail) begin
                        fatal_r <= chk_fatal;
                        sub_max_r <= sub_count;
                        rings_r <= pst_pkg::BELL_RINGS;
                        if (disp_ok_r) begin
                            state_r <= pst_pkg::PST_REP_NAME;
                        end else begin
                            state_r <= chk_fatal ? pst_pkg::PST_FATAL : pst_pkg::PST_SELECT;
                        end
                        if (!chk_fatal && !disp_ok_r) begin
                            idx_r <= idx_r + 5'h1;
                            state_r <= last_step ? pst_pkg::PST_DONE : pst_pkg::PST_SELECT;
                        end
                    end else if (chk_pass) begin
                        if (code_r == pst_pkg::CODE_DISPLAY_DONE) begin
                            disp_ok_r <= 1'b1;
                        end
                        idx_r <= idx_r + 5'h1;
                        state_r <= last_step ? pst_pkg::PST_DONE : pst_pkg::PST_SELECT;
                    end
                end
                pst_pkg::PST_REP_NAME: begin
                    rep_r <= 1'b1;
                    rep_line_r <= 1'b0;
                    rep_code_r <= code_r;
                    state_r <= pst_pkg::PST_REP_PART;
                end
                pst_pkg::PST_REP_PART: begin
                    rep_r <= 1'b1;
                    rep_line_r <= 1'b1;
                    rep_code_r <= sub_code;
                    if (fatal_r) begin
                        state_r <= pst_pkg::PST_FATAL;
                    end else begin
                        idx_r <= idx_r + 5'h1;
                        state_r <= last_step ? pst_pkg::PST_DONE : pst_pkg::PST_SELECT;
                    end
                end
                pst_pkg::PST_FATAL: begin
                    if (tick_r) begin
                        leds_r <= (leds_r == code_r) ? 8'h00 : code_r;
                        if (rings_r != 2'h0) begin
                            bell_r <= 1'b1;
                            rings_r <= rings_r - 2'h1;
                        end
                    end
                    if (return_press) begin
                        if (sub_max_r == 2'h0) begin
                            idx_r <= idx_r + 5'h1;
                            state_r <= last_step ? pst_pkg::PST_DONE : pst_pkg::PST_SELECT;
                        end else begin
                            sub_idx_r <= 2'h1;
                            state_r <= pst_pkg::PST_SUB;
                        end
                    end
                end
                pst_pkg::PST_SUB: begin
                    leds_r <= sub_code;
                    if (return_press) begin
                        if (sub_idx_r < sub_max_r) begin
                            sub_idx_r <= sub_idx_r + 2'h1;
                        end else begin
                            idx_r <= idx_r + 5'h1;
                            state_r <= last_step ? pst_pkg::PST_DONE : pst_pkg::PST_SELECT;
                        end
                    end
                end
                default: begin
                    done_r <= 1'b1;
                end
            endcase
        end
    end

    // ==========================================
    // Outputs
    assign indicator_leds = leds_r;
    assign shift_lock_lamp = shift_r;
    assign keyboard_lamps = lamps_r;
    assign bell = bell_r;
    assign check_start = start_r;
    assign check_code = code_r;
    assign sub_sel = sub_idx_r;
    assign report_valid = rep_r;
    assign report_line = rep_line_r;
    assign report_code = rep_code_r;
    assign delay_done = dly_done_r;
    assign delay_skip = skip_r;
    assign full_test = full_r;
    assign seq_done = done_r;

    // ==========================================
    // Assertions
    logic [2:0] bell_cnt_h;
    always_ff @(posedge clk) begin
        if (!rst_n || state_r != pst_pkg::PST_FATAL) begin
            bell_cnt_h <= 3'h0;
        end else if (bell_r) begin
            bell_cnt_h <= bell_cnt_h + 3'h1;
        end
    end

    sequence s_lamps;
        state_r == pst_pkg::PST_LAMPS;
    endsequence
    property p_lamps;
        @(posedge clk) disable iff (!rst_n) s_lamps |=> !shift_lock_lamp && indicator_leds == 8'hFF;
    endproperty
    a_lamps: assert property (p_lamps) else $error("shift lock not cleared");
    property p_code;
        @(posedge clk) disable iff (!rst_n) check_start |-> indicator_leds == check_code;
    endproperty
    a_code: assert property (p_code) else $error("lights differ from check code");
    property p_mode;
        @(posedge clk) disable iff (!rst_n) check_start && !full_test |-> !entry[pst_pkg::FULL_BIT];
    endproperty
    a_mode: assert property (p_mode) else $error("full-only step in power-up pass");
    property p_bells;
        @(posedge clk) disable iff (!rst_n) bell_cnt_h <= 3'h3;
    endproperty
    a_bells: assert property (p_bells) else $error("more than three bells");
    property p_hold;
        @(posedge clk) disable iff (!rst_n)
            state_r == pst_pkg::PST_RUN && !chk_pass && !chk_fail && !chk_fatal |=> $stable(indicator_leds);
    endproperty
    a_hold: assert property (p_hold) else $error("lights changed while check hung");
    property p_skip;
        @(posedge clk) disable iff (!rst_n) state_r == pst_pkg::PST_KEYS && ctrl_d |=> delay_skip;
    endproperty
    a_skip: assert property (p_skip) else $error("control-D not captured");
    property p_skip_done;
        @(posedge clk) disable iff (!rst_n) delay_req && delay_skip |=> delay_done;
    endproperty
    a_skip_done: assert property (p_skip_done) else $error("skipped wait not immediate");
    sequence s_wait_start;
        delay_req && !delay_skip;
    endsequence
    property p_wait;
        @(posedge clk) disable iff (!rst_n) s_wait_start |=> !delay_done [*2];
    endproperty
    a_wait: assert property (p_wait) else $error("delay wait ended early");
    property p_pass;
        @(posedge clk) disable iff (!rst_n)
            state_r == pst_pkg::PST_RUN && chk_pass && !chk_fail && !chk_fatal && !last_step
            |=> state_r == pst_pkg::PST_SELECT ##1 check_start || state_r != pst_pkg::PST_RUN;
    endproperty
    a_pass: assert property (p_pass) else $error("pass did not advance");
    property p_continue;
        @(posedge clk) disable iff (!rst_n)
            state_r == pst_pkg::PST_SUB && return_press && sub_sel == sub_max_r && !last_step
            |=> state_r == pst_pkg::PST_SELECT;
    endproperty
    a_continue: assert property (p_continue) else $error("return did not continue");
    property p_timeout;
        @(posedge clk) disable iff (!rst_n) state_r == pst_pkg::PST_KEYS && key_timeout |=> state_r != pst_pkg::PST_KEYS;
    endproperty
    a_timeout: assert property (p_timeout) else $error("key wait did not time out");
endmodule

// ===== dv/pst_operator_model.sv
`timescale 1ns/10ps
// ==========================================
// Operator keyboard and check engine model
module pst_operator_model (
    input wire logic clk, // System clock
    input wire logic rst_n, // Reset, low active
    input wire logic check_start, // Start check pulse
    input wire logic [7:0] check_code, // Current check
    input wire logic bell, // Bell strike
    input wire logic [1:0] sub_sel, // Level shown
    input wire logic key_en, // Operator answers key check
    input wire logic [7:0] fail_code, // Non-fatal failure here
    input wire logic [7:0] fatal_code, // Fatal failure here
    input wire logic [7:0] hang_code, // Never answers here
    input wire logic [1:0] sub_n, // Levels of a failure
    output logic chk_pass, // Check passed
    output logic chk_fail, // Non-fatal failure
    output logic chk_fatal, // Fatal failure
    output logic [1:0] sub_count, // Levels reported
    output logic [7:0] sub_code, // Code of level shown
    output logic key_press // Key struck
);
    logic busy_r;
    logic [1:0] wait_r;
    logic [7:0] code_r;
    logic [1:0] key_wait_r;
    logic key_arm_r;

    // Level codes follow the level shown
    assign sub_count = sub_n;
    assign sub_code = 8'h50 + {6'h00, sub_sel};

    // Answer each started check a few cycles later, except one at hang_code
    always_ff @(posedge clk) begin
        chk_pass <= 1'b0;
        chk_fail <= 1'b0;
        chk_fatal <= 1'b0;
        if (!rst_n) begin
            busy_r <= 1'b0;
        end else if (check_start) begin
            busy_r <= 1'b1;
            code_r <= check_code;
            wait_r <= 2'h2;
        end else if (busy_r && code_r != hang_code) begin
            if (wait_r != 2'h0) begin
                wait_r <= wait_r - 2'h1;
            end else begin
                busy_r <= 1'b0;
                chk_fatal <= code_r == fatal_code;
                chk_fail <= code_r == fail_code;
                chk_pass <= code_r != fatal_code && code_r != fail_code;
            end
        end
    end

    always_ff @(posedge clk) begin
        key_press <= 1'b0;
        if (!rst_n) begin
            key_arm_r <= 1'b0;
        end else if (bell && key_en) begin
            key_arm_r <= 1'b1;
            key_wait_r <= 2'h3;
        end else if (key_arm_r) begin
            key_wait_r <= key_wait_r - 2'h1;
            if (key_wait_r == 2'h0) begin
                key_arm_r <= 1'b0;
                key_press <= 1'b1;
            end
        end
    end
endmodule

// ===== dv/power_up_self_test_sequencer_tb_top.sv
`timescale 1ns/10ps
module power_up_self_test_sequencer_tb_top;
    logic clk = 1'b0, rst_n = 1'b0, self_test_btn = 1'b0, return_press = 1'b0, ctrl_d = 1'b0, delay_req = 1'b0;
    logic key_press, chk_pass, chk_fail, chk_fatal, bell, check_start, report_valid, report_line;
    logic delay_done, delay_skip, full_test, seq_done, shift_lock_lamp;
    logic [1:0] sub_count, sub_sel, sub_n = 2'h0;
    logic [3:0] keyboard_lamps;
    logic [7:0] sub_code, indicator_leds, check_code, report_code;
    logic [7:0] fail_code = 8'h00, fatal_code = 8'h00, hang_code = 8'h00;
    logic key_en = 1'b0;
    logic [7:0] seen_q [$];
    logic [8:0] rep_q [$];
    int num_errors = 0, comparisons = 0, bell_cnt = 0;
    // Check list, bit 8 marks full-test-only
    logic [8:0] step_tab [30] = '{9'h1FE, 9'h1FC, 9'h0EF, 9'h0EE, 9'h0EC, 9'h0DF, 9'h1BF, 9'h1BE,
        9'h0BD, 9'h0BC, 9'h0B5, 9'h0BA, 9'h0DE, 9'h1B9, 9'h1B8, 9'h0B7, 9'h0B6, 9'h0B4, 9'h0FA, 9'h0CE,
        9'h08F, 9'h18E, 9'h08D, 9'h08C, 9'h0AF, 9'h0EB, 9'h0DD, 9'h1DC, 9'h0CD, 9'h0CC};

    // ==========================================
    // Clock, design and operator
    always #4 clk = ~clk;
    pst_sequencer #(.DELAY_CYC(32'h14), .KEY_CYC(32'h32), .BLINK_CYC(32'h4)) i_pst_sequencer (.clk(clk),
        .rst_n(rst_n), .self_test_btn(self_test_btn), .key_press(key_press), .return_press(return_press),
        .ctrl_d(ctrl_d), .chk_pass(chk_pass), .chk_fail(chk_fail), .chk_fatal(chk_fatal),
        .sub_count(sub_count), .sub_code(sub_code), .delay_req(delay_req), .indicator_leds(indicator_leds),
        .shift_lock_lamp(shift_lock_lamp), .keyboard_lamps(keyboard_lamps), .bell(bell),
        .check_start(check_start), .check_code(check_code), .sub_sel(sub_sel), .report_valid(report_valid),
        .report_line(report_line), .report_code(report_code), .delay_done(delay_done),
        .delay_skip(delay_skip), .full_test(full_test), .seq_done(seq_done));
    pst_operator_model i_pst_operator_model (.clk(clk), .rst_n(rst_n), .check_start(check_start),
        .check_code(check_code), .bell(bell), .sub_sel(sub_sel), .key_en(key_en), .fail_code(fail_code),
        .fatal_code(fatal_code), .hang_code(hang_code), .sub_n(sub_n), .chk_pass(chk_pass),
        .chk_fail(chk_fail), .chk_fatal(chk_fatal), .sub_count(sub_count), .sub_code(sub_code),
        .key_press(key_press));

    // ==========================================
    // Report, compare and wait helpers
    task automatic print_verdict();
        $display("Comparisons %0d, errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask

    // Log started checks, bells and screen lines
    always @(posedge clk) begin
        if (check_start === 1'b1) begin
            seen_q.push_back(check_code);
            chk(indicator_leds, check_code, "lights");
        end
        if (bell === 1'b1) bell_cnt++;
        if (report_valid === 1'b1) rep_q.push_back({report_line, report_code});
    end

    task automatic do_reset(input logic full, input logic [7:0] fl, input logic [7:0] ft,
        input logic [7:0] hg, input logic [1:0] sn, input logic ke, input logic cd);
        @(posedge clk);
        rst_n <= 1'b0;
        self_test_btn <= full;
        {fail_code, fatal_code, hang_code, sub_n, key_en, ctrl_d} <= {fl, ft, hg, sn, ke, cd};
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        seen_q.delete();
        rep_q.delete();
        bell_cnt = 0;
        @(posedge clk);
        #1;
        chk({indicator_leds, keyboard_lamps, shift_lock_lamp}, 13'h1FFF, "all lamps on");
        @(posedge clk);
        #1;
        chk({indicator_leds, shift_lock_lamp}, 9'h1FE, "shift lamp off");
        // button let go after lights cycle
        repeat (4) @(posedge clk);
        self_test_btn <= 1'b0;
    endtask

    task automatic wait_done();
        int n;
        for (n = 0; n < 4000 && seq_done !== 1'b1; n++) @(posedge clk);
        if (n == 4000) begin
            num_errors++;
            $display("Error at %0t: sequence never completed", $time);
            print_verdict();
        end
    endtask

    task automatic cmp_seq(input logic full);
        logic [7:0] exp_q [$];
        foreach (step_tab[i])
            if ((full || !step_tab[i][8]) && step_tab[i][7:0] != 8'hFC) exp_q.push_back(step_tab[i][7:0]);
        chk(16'(seen_q.size()), 16'(exp_q.size()), "check count");
        foreach (exp_q[i])
            if (i < seen_q.size()) chk(seen_q[i], exp_q[i], "check order");
    endtask

    task automatic delay_cycles(output int n);
        @(posedge clk);
        delay_req <= 1'b1;
        @(posedge clk);
        delay_req <= 1'b0;
        // Count edges after the taking edge, pulse seen where it stands
        for (n = 0; n < 100; n++) begin
            #1;
            if (delay_done === 1'b1) break;
            @(posedge clk);
        end
    endtask

    task automatic key_gap(output int n);
        for (n = 0; n < 300 && bell !== 1'b1; n++) begin @(posedge clk); #1; end
        for (n = 0; n < 300 && check_start !== 1'b1; n++) begin @(posedge clk); #1; end
    endtask

    task automatic press_return();
        @(posedge clk);
        return_press <= 1'b1;
        @(posedge clk);
        return_press <= 1'b0;
        @(posedge clk);
        #1;
    endtask

    // ==========================================
    // Scenarios
    task automatic t_power_up();
        int n;
        do_reset(1'b0, 8'h00, 8'h00, 8'h00, 2'h0, 1'b1, 1'b0);
        wait_done();
        cmp_seq(1'b0);
        chk(full_test, 1'b0, "power-up mode");
        delay_cycles(n);
        chk(16'(n), 16'h14, "delay wait");
    endtask

    task automatic t_full_key_skip();
        int n;
        do_reset(1'b1, 8'h00, 8'h00, 8'h00, 2'h0, 1'b1, 1'b1);
        key_gap(n);
        chk(n < 50, 1'b1, "key answered early");
        wait_done();
        cmp_seq(1'b1);
        chk({full_test, delay_skip}, 2'h3, "full mode and skip");
        delay_cycles(n);
        chk(16'(n), 16'h0, "skipped delay");
    endtask

    task automatic t_key_timeout();
        int n;
        do_reset(1'b1, 8'h00, 8'h00, 8'h00, 2'h0, 1'b0, 1'b0);
        key_gap(n);
        chk(n >= 50 && n < 300, 1'b1, "key timeout");
        wait_done();
        cmp_seq(1'b1);
    endtask

    task automatic t_fatal_sub();
        int zeros = 0, lit = 0;
        do_reset(1'b0, 8'h00, 8'hB7, 8'h00, 2'h2, 1'b1, 1'b0);
        for (int n = 0; n < 2000 && bell_cnt == 0; n++) @(posedge clk);
        repeat (40) begin
            @(posedge clk);
            #1;
            zeros += (indicator_leds === 8'h00);
            lit += (indicator_leds === 8'hB7);
        end
        chk(16'(bell_cnt), 16'h3, "bell strikes");
        chk(zeros > 0 && lit > 0, 1'b1, "code blinks");
        for (int lvl = 1; lvl < 3; lvl++) begin
            press_return();
            chk({sub_sel, indicator_leds}, {lvl[1:0], 8'h50 + 8'(lvl)}, "submessage");
        end
        press_return();
        wait_done();
        cmp_seq(1'b0);
        chk(16'(rep_q.size()), 16'h0, "no screen before display");
    endtask

    task automatic t_report();
        do_reset(1'b0, 8'hAF, 8'h00, 8'h00, 2'h1, 1'b1, 1'b0);
        wait_done();
        cmp_seq(1'b0);
        chk(16'(rep_q.size()), 16'h2, "screen lines");
        if (rep_q.size() == 2) begin
            chk(16'(rep_q[0]), 16'h00AF, "screen name line");
            chk(16'(rep_q[1]), 16'h0150, "screen part line");
        end
    endtask

    task automatic t_hang();
        do_reset(1'b0, 8'h00, 8'h00, 8'hEB, 2'h0, 1'b1, 1'b0);
        repeat (600) @(posedge clk);
        #1;
        chk({indicator_leds, seq_done}, 9'h1D6, "stuck code lit");
    endtask

    // Main sequence
    initial begin
        t_power_up();
        t_full_key_skip();
        t_key_timeout();
        t_fatal_sub();
        t_report();
        t_hang();
        print_verdict();
    end
endmodule
